/* hw/timer_pkg.sv */
package timer_pkg;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int          ADDR_W = 4;
   localparam int          DATA_W = 16;
   localparam int          CTRL_W = 8;

   localparam logic [3:0]  ADDR_COUNT    = 4'h0;
   localparam logic [3:0]  ADDR_CCA      = 4'h1;
   localparam logic [3:0]  ADDR_CCB      = 4'h2;
   localparam logic [3:0]  ADDR_MODE     = 4'h3;
   localparam logic [3:0]  ADDR_PRESCALE = 4'h4;
   localparam logic [3:0]  ADDR_CAPCMP   = 4'h5;
   localparam logic [3:0]  ADDR_OUTCTL   = 4'h6;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          MODE_LSB      = 2;
   localparam int          CLK_SEL_LSB   = 0;
   localparam int          TRIG_EDGE_LSB = 4;
   localparam int          CAP_EDGE_LSB  = 6;

   localparam int          CC_A_CAPTURE  = 0;
   localparam int          CC_A_REVERSE  = 1;
   localparam int          CC_B_CAPTURE  = 2;

   localparam int          OC_ENABLE     = 0;
   localparam int          OC_TOGGLE_A   = 1;
   localparam int          OC_INIT_CLEAR = 2;
   localparam int          OC_INIT_SET   = 3;
   localparam int          OC_TOGGLE_B   = 4;

   localparam logic [7:0]  MODE_MASK     = 8'h0C;
   localparam logic [7:0]  PRESCALE_MASK = 8'hF3;
   localparam logic [7:0]  CAPCMP_MASK   = 8'h07;
   localparam logic [7:0]  OUTCTL_MASK   = 8'h13;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] COUNT_RST     = 16'h0000;
   localparam logic [15:0] CC_RST        = 16'h0000;
   localparam logic [7:0]  CTRL_RST      = 8'h00;

   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   localparam logic [1:0]  MODE_STOP        = 2'h0;
   localparam logic [1:0]  MODE_EDGE_CLEAR  = 2'h2;
   localparam logic [1:0]  MODE_MATCH_CLEAR = 2'h3;

   localparam logic [1:0]  CLK_DIV1   = 2'h0;
   localparam logic [1:0]  CLK_DIV4   = 2'h1;
   localparam logic [1:0]  CLK_DIV256 = 2'h2;
   localparam logic [1:0]  CLK_EXT    = 2'h3;

   localparam logic [1:0]  EDGE_FALL  = 2'h0;
   localparam logic [1:0]  EDGE_RISE  = 2'h1;
   localparam logic [1:0]  EDGE_BOTH  = 2'h3;

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   localparam int          PRE_W       = 8;
   localparam logic [1:0]  DIV4_LAST   = 2'h3;
   localparam logic [7:0]  DIV256_LAST = 8'hFF;
   localparam logic [7:0]  PRE_RST     = 8'h00;

endpackage : timer_pkg

/* hw/pin_edge_filter.sv */
`timescale 1ns/10ps
`default_nettype none

module pin_edge_filter (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);

   logic             sample_reg;
   logic             level_reg;

   // ----------------------------------------------------------------
   // accept a level only after two equal samples
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sample_reg <= 1'b0;
         level_reg  <= 1'b0;
         rise       <= 1'b0;
         fall       <= 1'b0;
      end else begin
         sample_reg <= pin;
         rise       <= 1'b0;
         fall       <= 1'b0;
         if ((pin == sample_reg) && (pin != level_reg)) begin
            level_reg <= pin;
            rise      <= pin;
            fall      <= ~pin;
         end
      end
   end

endmodule : pin_edge_filter

`default_nettype wire

/* hw/timer_event_counter.sv */
// Contract
// - mode 11 starts counting aligned to the selected count clock, clear on match.
// - match with register a clears counter, raises irq a, toggles if enabled.
// - match interval is M+1 count clocks; square wave period twice that.
// - register b match raises irq b even when b is unused.
// - clock select 11 with mode 11 counts trigger edges, irq a on match.
// - first event-mode irq after M+2 edges, later ones after M+1.
// - trigger edge valid only after two consecutive equal samples.
// - mode 10 counts up, trigger edge clears to zero and resumes.
// - mode 10 without trigger edges overflows and keeps counting.
// - mode 10 counts at once, no wait for a trigger edge.
// - mode 10 compare registers each raise their own irq on match.
// - capture a stores count on capture edge or reverse trigger edge.
// - capture b stores count on trigger edge, irq b, then clears.
// - counter register reads the current count in every mode.
// - clock select: 00 full, 01 by 4, 10 by 256, 11 trigger edge.
// - edge select: 00 falling, 01 rising, 11 both; 10 prohibited.
// - output disabled holds pin low; enabled follows toggle logic.
// - irq a raised on match even with toggling disabled.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module timer_event_counter
   import timer_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              trigger_input,
   input  wire logic              capture_input,
   output logic                   timer_out_pin,
   output logic                   match_irq_a,
   output logic                   match_irq_b
);

   logic [CNT_W-1:0]  count_value_reg;
   logic [CNT_W-1:0]  compare_capture_a_reg;
   logic [CNT_W-1:0]  compare_capture_b_reg;
   logic [CTRL_W-1:0] timer_mode_control_reg;
   logic [CTRL_W-1:0] prescale_select_reg;
   logic [CTRL_W-1:0] capcmp_control_reg;
   logic [CTRL_W-1:0] timer_output_control_reg;
   logic [PRE_W-1:0]  pre_reg;
   logic              started_reg;
   logic [DATA_W-1:0] rdata_next;

   logic [1:0]        op_mode;
   logic [1:0]        clk_sel;
   logic [1:0]        trigin_edge;
   logic [1:0]        capin_edge;
   logic              active;
   logic              edge_mode;
   logic              match_mode;
   logic              trig_rise;
   logic              trig_fall;
   logic              cap_rise;
   logic              cap_fall;
   logic              trig_hit;
   logic              trig_rev_hit;
   logic              cap_hit;
   logic              tick;
   logic              count_step;
   logic              a_is_cmp;
   logic              b_is_cmp;
   logic              match_a;
   logic              match_b;
   logic              cap_a_ev;
   logic              cap_b_ev;
   logic              toggle_ev;
   logic              wr_outctl;

   // ----------------------------------------------------------------
   // edge selection
   // ----------------------------------------------------------------
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       r,
                                     input logic       f);
      logic hit;
      hit = 1'b0;
      case (sel)
         EDGE_FALL: hit = f;
         EDGE_RISE: hit = r;
         EDGE_BOTH: hit = r | f;
         default:   hit = 1'b0;
      endcase
      return hit;
   endfunction : edge_hit

   pin_edge_filter u_trig_filter (
      .sys_clk (sys_clk),
      .srst    (srst),
      .pin     (trigger_input),
      .rise    (trig_rise),
      .fall    (trig_fall)
   );

   pin_edge_filter u_cap_filter (
      .sys_clk (sys_clk),
      .srst    (srst),
      .pin     (capture_input),
      .rise    (cap_rise),
      .fall    (cap_fall)
   );

   assign op_mode     = timer_mode_control_reg[MODE_LSB +: 2];
   assign clk_sel     = prescale_select_reg[CLK_SEL_LSB +: 2];
   assign trigin_edge = prescale_select_reg[TRIG_EDGE_LSB +: 2];
   assign capin_edge  = prescale_select_reg[CAP_EDGE_LSB +: 2];
   assign active      = (op_mode != MODE_STOP);
   assign edge_mode   = (op_mode == MODE_EDGE_CLEAR);
   assign match_mode  = (op_mode == MODE_MATCH_CLEAR);

   assign trig_hit     = edge_hit(trigin_edge, trig_rise, trig_fall);
   // opposite phase: swap rising and falling
   assign trig_rev_hit = edge_hit(trigin_edge, trig_fall, trig_rise);
   assign cap_hit      = edge_hit(capin_edge, cap_rise, cap_fall);

   // ----------------------------------------------------------------
   // count clock
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst || !active) begin
         pre_reg <= PRE_RST;
      end else begin
         pre_reg <= pre_reg + 1'b1;
      end
   end

   always_comb begin
      case (clk_sel)
         CLK_DIV1:   tick = 1'b1;
         CLK_DIV4:   tick = (pre_reg[1:0] == DIV4_LAST);
         CLK_DIV256: tick = (pre_reg == DIV256_LAST);
         default:    tick = trig_hit;
      endcase
   end

   // first tick in clear-on-match mode only aligns the start
   always_ff @(posedge sys_clk) begin
      if (srst || !active) begin
         started_reg <= 1'b0;
      end else if (tick) begin
         started_reg <= 1'b1;
      end
   end

   assign count_step = active && tick && (!match_mode || started_reg);

   // ----------------------------------------------------------------
   // events
   // ----------------------------------------------------------------
   assign a_is_cmp = match_mode || !capcmp_control_reg[CC_A_CAPTURE];
   assign b_is_cmp = match_mode || !capcmp_control_reg[CC_B_CAPTURE];

   assign match_a = count_step && a_is_cmp
                    && (count_value_reg == compare_capture_a_reg);
   assign match_b = count_step && b_is_cmp
                    && (count_value_reg == compare_capture_b_reg);

   assign cap_a_ev = edge_mode && capcmp_control_reg[CC_A_CAPTURE]
                     && (cap_hit || (capcmp_control_reg[CC_A_REVERSE]
                                     && trig_rev_hit));
   assign cap_b_ev = edge_mode && capcmp_control_reg[CC_B_CAPTURE]
                     && trig_hit;

   assign toggle_ev =
      (match_a && timer_output_control_reg[OC_TOGGLE_A]) ||
      (match_b && timer_output_control_reg[OC_TOGGLE_B]);

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         count_value_reg <= COUNT_RST;
      end else if (!active) begin
         count_value_reg <= COUNT_RST;
      end else if (edge_mode && trig_hit) begin
         count_value_reg <= COUNT_RST;
      end else if (count_step) begin
         if (match_mode && match_a) begin
            count_value_reg <= COUNT_RST;
         end else begin
            count_value_reg <= count_value_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt pulses
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         match_irq_a <= 1'b0;
         match_irq_b <= 1'b0;
      end else begin
         match_irq_a <= match_a || (edge_mode && cap_hit
                        && capcmp_control_reg[CC_A_CAPTURE]);
         match_irq_b <= match_b || cap_b_ev;
      end
   end

   // ----------------------------------------------------------------
   // timer output
   // ----------------------------------------------------------------
   assign wr_outctl = reg_wr && (reg_addr == ADDR_OUTCTL);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_out_pin <= 1'b0;
      end else if (wr_outctl && !reg_wdata[OC_ENABLE]) begin
         timer_out_pin <= 1'b0;
      end else if (wr_outctl && reg_wdata[OC_INIT_SET]) begin
         timer_out_pin <= 1'b1;
      end else if (wr_outctl && reg_wdata[OC_INIT_CLEAR]) begin
         timer_out_pin <= 1'b0;
      end else if (!timer_output_control_reg[OC_ENABLE]) begin
         timer_out_pin <= 1'b0;
      end else if (toggle_ev) begin
         timer_out_pin <= ~timer_out_pin;
      end
   end

   // ----------------------------------------------------------------
   // compare / capture registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         compare_capture_a_reg <= CC_RST;
      end else if (cap_a_ev) begin
         compare_capture_a_reg <= count_value_reg;
      end else if (reg_wr && (reg_addr == ADDR_CCA)) begin
         compare_capture_a_reg <= reg_wdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         compare_capture_b_reg <= CC_RST;
      end else if (cap_b_ev) begin
         compare_capture_b_reg <= count_value_reg;
      end else if (reg_wr && (reg_addr == ADDR_CCB)) begin
         compare_capture_b_reg <= reg_wdata[CNT_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         timer_mode_control_reg   <= CTRL_RST;
         prescale_select_reg      <= CTRL_RST;
         capcmp_control_reg       <= CTRL_RST;
         timer_output_control_reg <= CTRL_RST;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_MODE) begin
            timer_mode_control_reg <= reg_wdata[CTRL_W-1:0] & MODE_MASK;
         end else if (reg_addr == ADDR_PRESCALE) begin
            prescale_select_reg <= reg_wdata[CTRL_W-1:0] & PRESCALE_MASK;
         end else if (reg_addr == ADDR_CAPCMP) begin
            capcmp_control_reg <= reg_wdata[CTRL_W-1:0] & CAPCMP_MASK;
         end else if (reg_addr == ADDR_OUTCTL) begin
            timer_output_control_reg <= reg_wdata[CTRL_W-1:0] & OUTCTL_MASK;
         end
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = '0;
      if (reg_addr == ADDR_COUNT) begin
         rdata_next = DATA_W'(count_value_reg);
      end else if (reg_addr == ADDR_CCA) begin
         rdata_next = DATA_W'(compare_capture_a_reg);
      end else if (reg_addr == ADDR_CCB) begin
         rdata_next = DATA_W'(compare_capture_b_reg);
      end else if (reg_addr == ADDR_MODE) begin
         rdata_next = DATA_W'(timer_mode_control_reg);
      end else if (reg_addr == ADDR_PRESCALE) begin
         rdata_next = DATA_W'(prescale_select_reg);
      end else if (reg_addr == ADDR_CAPCMP) begin
         rdata_next = DATA_W'(capcmp_control_reg);
      end else if (reg_addr == ADDR_OUTCTL) begin
         rdata_next = DATA_W'(timer_output_control_reg);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || !reg_rd) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= rdata_next;
      end
   end

endmodule : timer_event_counter

`default_nettype wire

/* dv/timer_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module timer_sva
   import timer_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input wire logic              sys_clk,
   input wire logic              srst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              trigger_input,
   input wire logic              capture_input,
   input wire logic              timer_out_pin,
   input wire logic              match_irq_a,
   input wire logic              match_irq_b
);
   logic [1:0]  mode_q;
   logic [1:0]  clk_q;
   logic [15:0] cca_q;
   logic [16:0] gap_q;
   logic        armed_q;

   // shadow of the settings, cycles since last event a
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mode_q  <= 2'h0;
         clk_q   <= 2'h0;
         cca_q   <= 16'h0000;
         gap_q   <= 17'h00000;
         armed_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == ADDR_MODE) mode_q <= reg_wdata[3:2];
         if (reg_wr && reg_addr == ADDR_PRESCALE) clk_q <= reg_wdata[1:0];
         if (reg_wr && reg_addr == ADDR_CCA) cca_q <= reg_wdata;
         gap_q   <= match_irq_a ? 17'h00001 : gap_q + 17'h00001;
         armed_q <= reg_wr ? 1'b0 : (match_irq_a ? 1'b1 : armed_q);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   sequence s_stop;
      reg_wr && reg_addr == ADDR_MODE && reg_wdata[3:2] == MODE_STOP;
   endsequence
   sequence s_cnt_rd;
      reg_rd && reg_addr == ADDR_COUNT;
   endsequence
   property p_oc_rb;
      logic [15:0] v;
      (reg_wr && reg_addr == ADDR_OUTCTL, v = reg_wdata) ##2
      (reg_rd && reg_addr == ADDR_OUTCTL) |=>
      reg_rdata == (v & {8'h00, OUTCTL_MASK});
   endproperty

   chk_rdata_idle:
      assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not idle");
   chk_unmapped_zero:
      assert property (reg_rd && reg_addr > ADDR_OUTCTL |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   chk_outctl_readback:
      assert property (p_oc_rb)
      else $error("output control readback wrong");
   chk_out_low:
      assert property (reg_wr && reg_addr == ADDR_OUTCTL && !reg_wdata[OC_ENABLE]
                       |=> (!timer_out_pin) [*2])
      else $error("disabled output not low");
   chk_stop_count:
      assert property (s_stop ##2 s_cnt_rd |=> reg_rdata == 16'h0000)
      else $error("stopped count not zero");
   chk_stop_quiet:
      assert property (s_stop |=> ##1 (!match_irq_a && !match_irq_b) [*4])
      else $error("event while stopped");
   chk_interval_gap:
      assert property (match_irq_a && armed_q && mode_q == MODE_MATCH_CLEAR &&
                       clk_q == CLK_DIV1 |-> gap_q == {1'b0, cca_q} + 17'h00001)
      else $error("interval length wrong");
   chk_irq_a_pulse:
      assert property ($rose(match_irq_a) |=> !match_irq_a)
      else $error("event a longer than one cycle");
   chk_irq_b_pulse:
      assert property (match_irq_b |=> !match_irq_b)
      else $error("event b longer than one cycle");
endmodule : timer_sva

`default_nettype wire

/* dv/pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

module pin_model (
   input  wire logic sys_clk,
   output logic      trigger_input,
   output logic      capture_input
);
   initial begin
      trigger_input = 1'b0;
      capture_input = 1'b0;
   end
   // level held 7 cycles, well above the two-sample filter
   task toggle();
      @(posedge sys_clk) trigger_input <= ~trigger_input;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask : toggle
   // one-sample noise pulse
   task glitch();
      @(posedge sys_clk) trigger_input <= ~trigger_input;
      @(posedge sys_clk) trigger_input <= ~trigger_input;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask : glitch
   task cap_pulse();
      @(posedge sys_clk) capture_input <= 1'b1;
      repeat (6) @(posedge sys_clk);
      capture_input <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1;
   endtask : cap_pulse
endmodule : pin_model

`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   import timer_pkg::*;
   logic              sys_clk, srst, reg_wr, reg_rd, p0;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
   logic              trigger_input, capture_input;
   logic              timer_out_pin, match_irq_a, match_irq_b;
   int                mismatches, n_compared, n0, nb0, c, f, s;
   int                na = 0;
   int                nb = 0;
   int                dv[3] = '{1, 4, 256};
   int                ef[3] = '{6, 5, 3};
   int                es[3] = '{10, 9, 5};
   logic [1:0]        esel[3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};

   timer_event_counter dut_u (.sys_clk(sys_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_input(trigger_input),
      .capture_input(capture_input), .timer_out_pin(timer_out_pin),
      .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));
   pin_model pins_u (.sys_clk(sys_clk), .trigger_input(trigger_input),
      .capture_input(capture_input));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (match_irq_a === 1'b1) na <= na + 1;
      if (match_irq_b === 1'b1) nb <= nb + 1;
   end

   // ----------------------------------------------------------------
   // bus and check tasks
   // ----------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task cfg(input logic [1:0] m, input logic [7:0] p, input logic [15:0] a,
            input logic [15:0] b, input logic [7:0] cc, input logic [7:0] oc);
      wr(ADDR_MODE, 16'h0000);
      wr(ADDR_PRESCALE, {8'h00, p});
      wr(ADDR_CCA, a);
      wr(ADDR_CCB, b);
      wr(ADDR_CAPCMP, {8'h00, cc});
      wr(ADDR_OUTCTL, {8'h00, oc});
      wr(ADDR_MODE, {12'h000, m, 2'h0});
   endtask : cfg
   task wait_irq(input bit b, input int lim, output int cyc);
      int s0;
      s0 = b ? nb : na;
      cyc = 0;
      while ((b ? nb : na) == s0 && cyc < lim) begin
         @(posedge sys_clk);
         #1 cyc++;
      end
      if (cyc >= lim) begin
         mismatches++;
         $display("[ERR] %0t event missing", $time);
      end
   endtask : wait_irq
   task final_report();
      $display("mismatches %0d compared %0d", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   initial begin
      #(90000 * 20);
      mismatches++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {mismatches, n_compared} = '0;
      srst = 1'b1;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rd(4'(i), d);
         chk(d, 0);
      end
      rd(4'h9, d);
      chk(d, 0);
      wr(ADDR_COUNT, 16'h1234);
      rd(ADDR_COUNT, d);
      chk(d, 0);
      wr(ADDR_OUTCTL, 16'h00F3);
      rd(ADDR_OUTCTL, d);
      chk(d, 16'h0013);
      for (int i = 0; i < 3; i++) begin
         cfg(MODE_MATCH_CLEAR, 8'(i), 16'h0002, 16'h0001, 8'h00, 8'h03);
         wait_irq(0, 2000, c);
         wait_irq(0, 1000, c);
         p0 = timer_out_pin;
         nb0 = nb;
         wait_irq(0, 1000, c);
         chk(c, 3 * dv[i]);
         chk(timer_out_pin, !p0);
         chk(nb - nb0, 1);
      end
      wr(ADDR_OUTCTL, 16'h0001);
      p0 = timer_out_pin;
      wait_irq(0, 1000, c);
      wait_irq(0, 1000, c);
      chk(timer_out_pin, p0);
      wr(ADDR_OUTCTL, 16'h0009);
      @(posedge sys_clk);
      #1 chk(timer_out_pin, 1);
      wr(ADDR_OUTCTL, 16'h0005);
      @(posedge sys_clk);
      #1 chk(timer_out_pin, 0);
      wr(ADDR_OUTCTL, 16'h0009);
      @(posedge sys_clk);
      #1 chk(timer_out_pin, 1);
      wr(ADDR_OUTCTL, 16'h0000);
      @(posedge sys_clk);
      #1 chk(timer_out_pin, 0);
      wr(ADDR_MODE, 16'h0000);
      rd(ADDR_COUNT, d);
      chk(d, 0);
      for (int j = 0; j < 3; j++) begin
         cfg(MODE_MATCH_CLEAR, {2'h0, esel[j], 2'h0, CLK_EXT}, 16'h0001, 16'hFFFF, 8'h00, 8'h00);
         n0 = na;
         f = 0;
         s = 0;
         pins_u.glitch();
         for (int k = 1; k <= 10; k++) begin
            pins_u.toggle();
            if (na - n0 == 1 && f == 0) f = k;
            if (na - n0 == 2 && s == 0) s = k;
         end
         chk(f, ef[j]);
         chk(s, es[j]);
      end
      cfg(MODE_EDGE_CLEAR, 8'h10, 16'h0005, 16'h0020, 8'h00, 8'h11);
      n0 = na;
      wait_irq(0, 20, c);
      chk(na - n0, 1);
      n0 = na;
      nb0 = nb;
      repeat (20) pins_u.toggle();
      chk(na - n0, 10);
      chk(nb - nb0, 0);
      nb0 = nb;
      wait_irq(1, 40, c);
      chk(nb - nb0, 1);
      p0 = timer_out_pin;
      wait_irq(1, 70000, c);
      chk(c, 65536);
      chk(timer_out_pin, !p0);
      cfg(MODE_EDGE_CLEAR, 8'h10, 16'h7FFF, 16'h0000, 8'h04, 8'h00);
      nb0 = nb;
      repeat (12) pins_u.toggle();
      chk(nb - nb0, 6);
      rd(ADDR_CCB, d);
      chk(d, 16'h000D);
      cfg(MODE_EDGE_CLEAR, 8'h50, 16'h0000, 16'h0000, 8'h07, 8'h00);
      n0 = na;
      repeat (6) pins_u.toggle();
      chk(na - n0, 0);
      rd(ADDR_CCA, d);
      chk(d, 16'h0006);
      repeat (3) pins_u.cap_pulse();
      chk(na - n0, 3);
      final_report();
   end
endmodule : tb_top

bind timer_event_counter timer_sva #(.CNT_W(CNT_W)) sva_u (
   .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .trigger_input(trigger_input),
   .capture_input(capture_input), .timer_out_pin(timer_out_pin),
   .match_irq_a(match_irq_a), .match_irq_b(match_irq_b));

`default_nettype wire
